// >>> shared/char_display_pkg.sv
// constants and types shared by the character display instruction unit
package char_display_pkg;
   localparam int DATA_W = 8;
   localparam int AC_W = 7;
   localparam int CG_AW = 6;
   localparam int CG_DW = 5;
   localparam int DD_DEPTH = 128;
   localparam int CG_DEPTH = 64;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [6:0] AC_RESET = 7'h00;
   localparam logic [6:0] LINE1_END = 7'h27;
   localparam logic [6:0] LINE2_BASE = 7'h40;
   localparam logic [6:0] LINE2_END = 7'h67;
   localparam logic [5:0] SHIFT_LAST = 6'h27;
   localparam logic [5:0] SHIFT_SPAN = 6'h28;
   localparam logic [5:0] OFFSET_RESET = 6'h00;
   localparam logic ENTRY_INC_RESET = 1'b1;
   localparam logic ENTRY_SHIFT_RESET = 1'b0;
   localparam logic DISPLAY_ON_RESET = 1'b0;
   localparam logic CURSOR_ON_RESET = 1'b0;
   localparam logic BLINK_ON_RESET = 1'b0;
   localparam logic BUS_WIDTH_RESET = 1'b1;
   localparam logic TWO_LINES_RESET = 1'b1;
   localparam logic [1:0] LUMINANCE_RESET = 2'h0;
   localparam logic [2:0] CURSOR_ROW = 3'h7;
   localparam logic [4:0] ALL_PIXELS = 5'h1F;
   localparam logic ADDR_INSTR = 1'b0;
   localparam logic ADDR_DATA = 1'b1;
   localparam int CLK_MHZ = 100;
   localparam int BLINK_HALF_MS = 500;
   localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * 1000 * CLK_MHZ;
   localparam int BLINK_CNT_W = 26;

   typedef enum logic [3:0] {
      INS_NONE,
      INS_CLEAR,
      INS_HOME,
      INS_ENTRY,
      INS_DISPLAY,
      INS_SHIFT,
      INS_FUNC,
      INS_CG_ADDR,
      INS_DD_ADDR
   } instr_type;
endpackage

// >>> src/char_display_instruction_unit.sv
// instruction interpreter, display and glyph memories, scan-out logic
// Functional notes
// - eight 5x8 glyphs at pattern addresses 00H-3FH
// - pattern memory keeps only low five bits
// - codes 00H-0FH select glyphs, bit3 ignored
// - pattern bit 1 lights pixel, 0 dark
// - clear fills spaces, homes, unshifts, sets increment
// - home zeroes counter and cancels shift
// - decrement mode; write shifts display right
// - increment mode; write shifts display left
// - shift-enable bit gates automatic write shifting
// - never shift on reads or pattern access
// - display-on zero blanks whole display
// - cursor lights eighth row at counter
// - blink alternates cursor character with block
// - shift instruction steps counter, no memory access
// - shift direction and select bit behaviour
// - shift instruction leaves counter in display memory
// - counter read returns busy zero and counter
// - pattern address set loads six bits
// - pattern addressing wraps 3FH and 00H
`timescale 1ns/1ps
module char_display_instruction_unit
   import char_display_pkg::*;
#(
   parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
   input wire logic ref_clk, // 100 MHz clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic addr, // register_select: 0 instruction, 1 data
   input wire logic [7:0] wdata, // write byte
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [7:0] rdata, // read byte, cycle after rd
   input wire logic scan_line, // scanned line, 0 or 1
   input wire logic [3:0] scan_col, // scanned column 0..15
   input wire logic [2:0] scan_row, // scanned pixel row 0..7
   output logic [7:0] scan_code, // character code at position
   output logic scan_user, // code selects a user glyph
   output logic [4:0] scan_pixels, // glyph row pixels incl. overlay
   output logic [4:0] scan_overlay, // cursor/blink mask for font rom
   output logic scan_enable, // display on
   output logic bus_width_bit, // bus width from function set
   output logic two_lines, // line count from function set
   output logic luminance_level_hi, // brightness high bit
   output logic luminance_level_lo // brightness low bit
);

   logic [7:0] display_char_memory [DD_DEPTH];
   logic [CG_DW-1:0] glyph_pattern_memory [CG_DEPTH];
   logic [AC_W-1:0] address_counter;
   logic ac_in_glyph;
   logic [5:0] shift_offset;
   logic entry_inc;
   logic entry_shift;
   logic cursor_on;
   logic blink_on;
   logic blink_phase;
   logic [BLINK_CNT_W-1:0] blink_cnt;

   function automatic instr_type decode_instr(input logic [7:0] b);
      if (b[7]) return INS_DD_ADDR;
      else if (b[6]) return INS_CG_ADDR;
      else if (b[5]) return INS_FUNC;
      else if (b[4]) return INS_SHIFT;
      else if (b[3]) return INS_DISPLAY;
      else if (b[2]) return INS_ENTRY;
      else if (b[1]) return INS_HOME;
      else if (b[0]) return INS_CLEAR;
      else return INS_NONE;
   endfunction

   // display addresses skip the gaps between the two lines
   function automatic logic [6:0] step_display(input logic [6:0] a,
                                               input logic inc);
      if (inc) begin
         if (a == LINE1_END) return LINE2_BASE;
         else if (a == LINE2_END) return AC_RESET;
         else return a + 7'h01;
      end else begin
         if (a == LINE2_BASE) return LINE1_END;
         else if (a == AC_RESET) return LINE2_END;
         else return a - 7'h01;
      end
   endfunction

   function automatic logic [5:0] step_offset(input logic [5:0] o,
                                              input logic left);
      if (left) return (o == SHIFT_LAST) ? OFFSET_RESET : o + 6'h01;
      else return (o == OFFSET_RESET) ? SHIFT_LAST : o - 6'h01;
   endfunction

   instr_type ins;
   wire instr_wr = wr && (addr == ADDR_INSTR);
   wire data_wr = wr && (addr == ADDR_DATA);
   wire data_rd = rd && (addr == ADDR_DATA);
   wire data_access = data_wr || data_rd;
   assign ins = instr_wr ? decode_instr(wdata) : INS_NONE;

   // pattern addressing wraps in six bits by construction
   wire [5:0] glyph_next = entry_inc ? address_counter[5:0] + 6'h01
                                     : address_counter[5:0] - 6'h01;
   wire [6:0] data_next_ac = ac_in_glyph ? {1'b0, glyph_next}
                           : step_display(address_counter, entry_inc);
   wire data_shift = data_wr && !ac_in_glyph && entry_shift;

   logic [6:0] next_ac;
   logic [5:0] next_offset;
   always_comb begin
      next_ac = address_counter;
      next_offset = shift_offset;
      if (data_access) begin
         next_ac = data_next_ac;
         if (data_shift) begin
            next_offset = step_offset(shift_offset, entry_inc);
         end
      end
      unique case (ins)
         INS_CLEAR, INS_HOME: begin
            next_ac = AC_RESET;
            next_offset = OFFSET_RESET;
         end
         INS_SHIFT: begin
            next_ac = step_display(address_counter, wdata[2]);
            if (wdata[3]) begin
               next_offset = step_offset(shift_offset, !wdata[2]);
            end
         end
         INS_CG_ADDR: next_ac = {1'b0, wdata[5:0]};
         INS_DD_ADDR: next_ac = wdata[6:0];
         INS_NONE, INS_ENTRY, INS_DISPLAY, INS_FUNC: begin
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         address_counter <= AC_RESET;
         shift_offset <= OFFSET_RESET;
         ac_in_glyph <= 1'b0;
      end else begin
         address_counter <= next_ac;
         shift_offset <= next_offset;
         if (ins == INS_CG_ADDR) ac_in_glyph <= 1'b1;
         else if (ins != INS_NONE && ins != INS_ENTRY &&
                  ins != INS_DISPLAY && ins != INS_FUNC)
            ac_in_glyph <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         entry_inc <= ENTRY_INC_RESET;
         entry_shift <= ENTRY_SHIFT_RESET;
         scan_enable <= DISPLAY_ON_RESET;
         cursor_on <= CURSOR_ON_RESET;
         blink_on <= BLINK_ON_RESET;
         bus_width_bit <= BUS_WIDTH_RESET;
         two_lines <= TWO_LINES_RESET;
         {luminance_level_hi, luminance_level_lo} <= LUMINANCE_RESET;
      end else begin
         if (ins == INS_CLEAR) entry_inc <= 1'b1;
         if (ins == INS_ENTRY) begin
            entry_inc <= wdata[1];
            entry_shift <= wdata[0];
         end
         if (ins == INS_DISPLAY) begin
            scan_enable <= wdata[2];
            cursor_on <= wdata[1];
            blink_on <= wdata[0];
         end
         if (ins == INS_FUNC) begin
            bus_width_bit <= wdata[4];
            two_lines <= wdata[3];
            {luminance_level_hi, luminance_level_lo} <= wdata[1:0];
         end
      end
   end

   // clear rewrites every location in one cycle; the host never waits
   always_ff @(posedge ref_clk) begin
      if (!rst_n || ins == INS_CLEAR) begin
         for (int i = 0; i < DD_DEPTH; i++) begin
            display_char_memory[i] <= SPACE_CODE;
         end
      end else if (data_wr && !ac_in_glyph) begin
         display_char_memory[address_counter] <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (data_wr && ac_in_glyph) begin
         glyph_pattern_memory[address_counter[5:0]] <= wdata[4:0];
      end
   end

   wire [7:0] data_read_byte = ac_in_glyph
      ? {3'h0, glyph_pattern_memory[address_counter[5:0]]}
      : display_char_memory[address_counter];

   always_ff @(posedge ref_clk) begin
      if (!rst_n) rdata <= 8'h00;
      else if (data_rd) rdata <= data_read_byte;
      else if (rd) rdata <= {1'b0, address_counter};
      else rdata <= 8'h00;
   end

   // half-period counter; shorten BLINK_HALF in simulation
   wire blink_wrap = (blink_cnt == BLINK_CNT_W'(BLINK_HALF - 1));
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         blink_cnt <= '0;
         blink_phase <= 1'b0;
      end else if (blink_wrap) begin
         blink_cnt <= '0;
         blink_phase <= !blink_phase;
      end else begin
         blink_cnt <= blink_cnt + BLINK_CNT_W'(1);
      end
   end

   // scan position to display address through the shift offset
   wire [5:0] col_sum = 6'(scan_col) + shift_offset;
   wire [5:0] col_wrap = (col_sum >= SHIFT_SPAN) ? col_sum - SHIFT_SPAN
                                                 : col_sum;
   wire [6:0] scan_addr = {scan_line, col_wrap};
   wire [7:0] code_here = display_char_memory[scan_addr];
   wire is_user = (code_here[7:4] == 4'h0);
   wire [5:0] glyph_addr = {code_here[2:0], scan_row};
   wire at_cursor = !ac_in_glyph && (scan_addr == address_counter);
   wire cursor_lit = cursor_on && at_cursor &&
                     (scan_row == CURSOR_ROW);
   wire blink_lit = blink_on && at_cursor && blink_phase;
   wire [4:0] overlay = (cursor_lit || blink_lit) ? ALL_PIXELS : 5'h00;
   wire [4:0] glyph_bits = is_user ? glyph_pattern_memory[glyph_addr]
                                   : 5'h00;

   always_ff @(posedge ref_clk) begin
      if (!rst_n || !scan_enable) begin
         scan_code <= 8'h00;
         scan_user <= 1'b0;
         scan_pixels <= 5'h00;
         scan_overlay <= 5'h00;
      end else begin
         scan_code <= code_here;
         scan_user <= is_user;
         scan_pixels <= glyph_bits | overlay;
         scan_overlay <= overlay;
      end
   end

   // function set first is the host's duty; nothing is refused here

   sequence s_ins_wr(logic [7:0] v, logic [7:0] m);
      instr_wr && ((wdata & m) == v);
   endsequence
   sequence s_glyph_wr;
      data_wr && ac_in_glyph;
   endsequence

   a_clear_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_ins_wr(8'h01, 8'hFF) |=> address_counter == AC_RESET &&
      shift_offset == OFFSET_RESET && entry_inc && !ac_in_glyph &&
      display_char_memory[LINE2_END] == SPACE_CODE)
      else $error("clear did not reset state");
   a_home_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_ins_wr(8'h02, 8'hFE) |=> address_counter == AC_RESET &&
      shift_offset == OFFSET_RESET)
      else $error("home did not reset counter");
   a_ac_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd && addr == ADDR_INSTR |=>
      rdata == {1'b0, $past(address_counter)})
      else $error("counter read wrong");
   a_glyph_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_glyph_wr |=>
      glyph_pattern_memory[$past(address_counter[5:0])] == $past(wdata[4:0]))
      else $error("glyph byte not kept");
   a_glyph_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_glyph_wr and (entry_inc && address_counter == 7'h3F) |=>
      address_counter == AC_RESET && ac_in_glyph)
      else $error("pattern wrap wrong");
   a_no_auto_shift: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (data_rd or s_glyph_wr) and !instr_wr |=>
      $stable(shift_offset))
      else $error("display shifted on read");
   a_shift_leaves: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_ins_wr(8'h10, 8'hF0) |=> !ac_in_glyph)
      else $error("shift left counter in pattern");
   a_entry_shift: assert property (@(posedge ref_clk) disable iff (!rst_n)
      data_wr && !ac_in_glyph && entry_shift && entry_inc |=>
      shift_offset == step_offset($past(shift_offset), 1'b1))
      else $error("write shift left missing");
   a_blink_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(blink_phase) |->
      $past(blink_cnt) == BLINK_CNT_W'(BLINK_HALF - 1))
      else $error("blink toggled off period");
   a_blank_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_ins_wr(8'h08, 8'hFC) |=> ##1 scan_pixels == 5'h00 &&
      scan_overlay == 5'h00)
      else $error("display not blanked");
endmodule

// >>> testbench/host_model.sv
// host bus master model for the instruction unit register port
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk, // clock
   input wire logic [7:0] rdata, // read byte from the unit
   output logic addr, // register select
   output logic [7:0] wdata, // write byte
   output logic wr, // write strobe
   output logic rd // read strobe
);
   initial begin
      addr = 1'b0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // byte is inverted after the strobe so a stale value never looks valid
   task automatic put(input logic a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
      wdata <= ~d;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic get(input logic a, output logic [7:0] q);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      q = rdata;
   endtask
endmodule

// >>> testbench/char_display_instruction_unit_test.sv
// self-checking bench for the character display instruction unit
`timescale 1ns/1ps
module char_display_instruction_unit_test;
   import char_display_pkg::*;
   logic ref_clk;
   logic rst_n;
   logic addr, wr, rd, scan_line, scan_user, scan_enable;
   logic [7:0] wdata, rdata, scan_code, q;
   logic [3:0] scan_col;
   logic [2:0] scan_row;
   logic [4:0] scan_pixels, scan_overlay;
   logic bus_width_bit, two_lines, lum_hi, lum_lo;
   int err_count = 0;
   int total_checks = 0;
   int ones;
   char_display_instruction_unit #(.BLINK_HALF(16)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .scan_line(scan_line),
      .scan_col(scan_col), .scan_row(scan_row), .scan_code(scan_code),
      .scan_user(scan_user), .scan_pixels(scan_pixels),
      .scan_overlay(scan_overlay), .scan_enable(scan_enable),
      .bus_width_bit(bus_width_bit), .two_lines(two_lines),
      .luminance_level_hi(lum_hi), .luminance_level_lo(lum_lo));
   host_model u_host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ins(input logic [7:0] d);
      u_host.put(1'b0, d);
   endtask
   task automatic dat(input logic [7:0] d);
      u_host.put(1'b1, d);
   endtask
   task automatic rd_ac(input logic [7:0] e);
      u_host.get(1'b0, q);
      chk(q, e);
   endtask
   task automatic scan(input logic l, input logic [3:0] c,
         input logic [2:0] r);
      @(posedge ref_clk);
      scan_line <= l;
      scan_col <= c;
      scan_row <= r;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic t_reset();
      chk({4'h0, bus_width_bit, two_lines, lum_hi, lum_lo}, 8'h0C);
      chk({7'h00, scan_enable}, 8'h00);
      ins(8'h21);
      chk({4'h0, bus_width_bit, two_lines, lum_hi, lum_lo}, 8'h01);
      ins(8'h3B);
      chk({4'h0, bus_width_bit, two_lines, lum_hi, lum_lo}, 8'h0F);
      rd_ac(8'h00);
   endtask
   task automatic t_glyph();
      ins(8'h4F);
      dat(8'hFF);
      rd_ac(8'h10);
      ins(8'h4F);
      u_host.get(1'b1, q);
      chk(q, 8'h1F);
      ins(8'h4B);
      dat(8'hEA);
      ins(8'h7F);
      dat(8'h15);
      rd_ac(8'h00);
      ins(8'h04);
      ins(8'h40);
      dat(8'h00);
      rd_ac(8'h3F);
      ins(8'h06);
   endtask
   task automatic t_show();
      ins(8'h0C);
      ins(8'h80);
      dat(8'h09);
      scan(1'b0, 4'h0, 3'h3);
      chk(scan_code, 8'h09);
      chk({7'h00, scan_user}, 8'h01);
      chk({3'h0, scan_pixels}, 8'h0A);
      ins(8'h0E);
      scan(1'b0, 4'h1, 3'h7);
      chk({3'h0, scan_overlay}, 8'h1F);
      scan(1'b0, 4'h1, 3'h6);
      chk({3'h0, scan_overlay}, 8'h00);
      ins(8'h08);
      scan(1'b0, 4'h0, 3'h3);
      chk({scan_code[6:0], scan_enable}, 8'h00);
      chk({3'h0, scan_pixels}, 8'h00);
      ins(8'h0C);
   endtask
   task automatic t_entry();
      ins(8'h01);
      dat(8'h41);
      dat(8'h42);
      rd_ac(8'h02);
      ins(8'h07);
      dat(8'h43);
      scan(1'b0, 4'h0, 3'h0);
      chk(scan_code, 8'h42);
      ins(8'h80);
      u_host.get(1'b1, q);
      chk(q, 8'h41);
      scan(1'b0, 4'h0, 3'h0);
      chk(scan_code, 8'h42);
      ins(8'h02);
      rd_ac(8'h00);
      scan(1'b0, 4'h0, 3'h0);
      chk(scan_code, 8'h41);
      ins(8'h05);
      ins(8'h81);
      dat(8'h44);
      rd_ac(8'h00);
      scan(1'b0, 4'h1, 3'h0);
      chk(scan_code, 8'h41);
      ins(8'h04);
      ins(8'h01);
      scan(1'b0, 4'h1, 3'h0);
      chk(scan_code, 8'h20);
      dat(8'h01);
      rd_ac(8'h01);
      scan(1'b0, 4'h0, 3'h3);
      chk({3'h0, scan_pixels}, 8'h0A);
   endtask
   task automatic t_shift();
      ins(8'h03);
      ins(8'h14);
      rd_ac(8'h01);
      ins(8'h10);
      rd_ac(8'h00);
      ins(8'h1C);
      scan(1'b0, 4'h1, 3'h3);
      chk(scan_code, 8'h01);
      ins(8'h18);
      rd_ac(8'h00);
      ins(8'h45);
      ins(8'h14);
      rd_ac(8'h06);
      dat(8'h55);
      ins(8'h86);
      u_host.get(1'b1, q);
      chk(q, 8'h55);
      ins(8'h00);
      rd_ac(8'h07);
   endtask
   task automatic t_blink();
      ins(8'h0D);
      scan(1'b0, 4'h7, 3'h0);
      ones = 0;
      // two full blink periods at a half period of 16 cycles
      repeat (64) begin
         @(posedge ref_clk);
         #1;
         if (scan_overlay === ALL_PIXELS) ones++;
      end
      chk(ones[7:0], 8'h20);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #200000;
      err_count++;
      conclude();
   end
   initial begin
      rst_n = 1'b0;
      scan_line = 1'b0;
      scan_col = 4'h0;
      scan_row = 3'h0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      t_reset();
      t_glyph();
      t_show();
      t_entry();
      t_shift();
      t_blink();
      conclude();
   end
endmodule
